// *** hw/acq_strobe_cfg.svh ***
/*
  Constants of the acquisition strobe timer: register byte offsets,
  field positions, reset values and timing figures.
  Assumes a 32-bit Avalon-MM slave with byte addressing.
*/
`ifndef ACQ_STROBE_CFG_SVH
`define ACQ_STROBE_CFG_SVH

// register byte offsets
`define REG_CONTROL 8'h00
`define REG_TRIGGER_DELAY 8'h04
`define REG_RISE_DELAY 8'h08
`define REG_FALL_DELAY 8'h0c
`define REG_CONT_PERIOD 8'h10
`define REG_STATUS 8'h14
`define REG_FRAME_COUNT 8'h18
`define REG_PULSE_WIDTH 8'h1c

// control field positions
`define CTRL_LAMP_BIT 0
`define CTRL_CONT_BIT 1
`define CTRL_EXT_BIT 2
`define CTRL_SOFT_BIT 8

// reset values
`define RST_CONTROL 3'h0
`define RST_TRIGGER_DELAY 16'h0000
`define RST_RISE_DELAY 16'h0000
`define RST_FALL_DELAY 16'h0000
`define RST_CONT_PERIOD 27'h00007d0

// timing figures
`define CORE_CLK_HZ 20000000
`define STEP_NS 500
`define START_LATENCY_NS 8200
`define TRANSFER_NS 8500
`define CONT_PERIOD_MIN_NS 2000
`define CONT_PERIOD_MAX_S 60
`define FRAME_PIXELS 128

`endif

// *** hw/acq_strobe_pkg.sv ***
/*
  Types of the acquisition strobe timer: control fields, status fields
  and acquisition states.
  Assumes the constants of acq_strobe_cfg.svh alongside.
*/
package acq_strobe_pkg;

  typedef struct packed {
    logic ext_trig_enable;
    logic cont_enable;
    logic lamp_enable;
  } ctrl_type;

  typedef struct packed {
    logic width_valid;
    logic readout_active;
    logic delay_pending;
    logic transfer_gate;
    logic cont_strobe;
    logic single_strobe;
  } status_type;

  typedef enum logic [1:0] {
    ACQ_IDLE = 2'b00,
    ACQ_DELAY = 2'b01,
    ACQ_TRANSFER = 2'b10
  } acq_state_type;

endpackage

// *** hw/cont_strobe_gen.sv ***
/*
  Free-running square wave generator for the continuous strobe.
  Assumes a half period in clock cycles of at least two, held stable
  by the caller.
*/
`timescale 1ns/100ps
module cont_strobe_gen
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic run_in,
  input wire logic [31:0] half_cycles_in,
  output logic wave_out
);

  logic [31:0] count_reg;
  logic [31:0] count_next;
  logic wave_reg;
  logic wave_next;

  // toggle every half period, park low when stopped
  always_comb
  begin
    count_next = count_reg;
    wave_next = wave_reg;
    if (!run_in)
    begin
      count_next = 32'h0;
      wave_next = 1'b0;
    end
    else if (count_reg >= half_cycles_in - 32'h1)
    begin
      count_next = 32'h0;
      wave_next = ~wave_reg;
    end
    else
    begin
      count_next = count_reg + 32'h1;
    end
  end

  // registers
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      count_reg <= 32'h0;
      wave_reg <= 1'b0;
    end
    else
    begin
      count_reg <= count_next;
      wave_reg <= wave_next;
    end
  end

  assign wave_out = wave_reg;

endmodule

// *** hw/acquisition_strobe_timing.sv ***
/*
  Acquisition start and lamp strobe timing with an Avalon-MM register
  slave: trigger delay, transfer gate, single strobe, continuous strobe
  and the 128-pixel readout sequence.
  Assumes a 20 MHz core clock, an asynchronous trigger pin and a master
  that holds each request until waitrequest is seen low.
*/
// Register access over Avalon-MM and the register offsets were decided locally.
// Summary of operation
// - strobe rises at rise delay, falls at fall delay
// - delays count 500ns steps, zero to 65535
// - single strobe only while lamp enabled
// - timing measured from transfer gate rising edge
// - fixed latency from external trigger to start
// - software starts also launch the single strobe
// - trigger delay postpones start beyond inherent latency
// - strobe rise at delay plus rise plus 8.2us
// - transfer and reset last about 8-9us
// - continuous strobe 50% duty, period 2us-60s
// - continuous strobe free-running, not start aligned
// - continuous strobe toggles only with lamp enabled
// - each frame reads out 128 active pixels
`timescale 1ns/100ps
`include "acq_strobe_cfg.svh"
module acquisition_strobe_timing
#(
  parameter int unsigned CONT_PERIOD_MAX_STEPS =
    `CONT_PERIOD_MAX_S * (1000000000 / `STEP_NS),
  parameter int unsigned PIXEL_COUNT = `FRAME_PIXELS
)
(
  input wire logic CORE_CLK_IN,
  input wire logic RST_N_IN,
  input wire logic [7:0] AVS_ADDRESS_IN,
  input wire logic AVS_READ_IN,
  input wire logic AVS_WRITE_IN,
  input wire logic [31:0] AVS_WRITEDATA_IN,
  input wire logic [3:0] AVS_BYTEENABLE_IN,
  output logic [31:0] AVS_READDATA_OUT,
  output logic AVS_WAITREQUEST_OUT,
  input wire logic EXT_TRIGGER_IN,
  output logic DETECTOR_TRANSFER_GATE_OUT,
  output logic INTEGRATION_START_OUT,
  output logic SINGLE_STROBE_OUT,
  output logic CONT_STROBE_OUT,
  output logic PIXEL_STROBE_OUT,
  output logic [$clog2(PIXEL_COUNT)-1:0] PIXEL_INDEX_OUT,
  output logic PIXEL_LAST_OUT
);

  localparam int IDX_W = $clog2(PIXEL_COUNT);
  localparam int CLK_NS = 1000000000 / `CORE_CLK_HZ;
  localparam int STEP_CYC = `STEP_NS / CLK_NS;
  localparam int HALF_STEP_CYC = STEP_CYC / 2;
  localparam int LAT_CYC = (`START_LATENCY_NS + CLK_NS - 1) / CLK_NS;
  localparam int SYNC_CYC = 3; // pin to state change overhead
  localparam int XFER_CYC = `TRANSFER_NS / CLK_NS;
  localparam int PERIOD_MIN_STEPS = `CONT_PERIOD_MIN_NS / `STEP_NS;

  // register file
  acq_strobe_pkg::ctrl_type ctrl_reg, ctrl_next;
  logic [15:0] trig_delay_reg, trig_delay_next;
  logic [15:0] rise_reg, rise_next;
  logic [15:0] fall_reg, fall_next;
  logic [26:0] period_reg, period_next;
  logic [31:0] readdata_reg, readdata_next;
  logic waitreq_reg, waitreq_next;
  logic [31:0] be_mask;
  logic [31:0] wr_bits;
  logic wr_fire;
  logic soft_trig;
  logic width_valid;
  acq_strobe_pkg::status_type status;

  // trigger synchroniser
  logic trig_meta_reg, trig_sync_reg, trig_prev_reg;
  logic trig_edge;

  // acquisition sequencer
  acq_strobe_pkg::acq_state_type state_reg, state_next;
  logic [19:0] cnt_reg, cnt_next;
  logic [19:0] delay_target;
  logic soi_reg, soi_next;
  logic gate_reg, gate_next;
  logic readout_start;

  // single strobe
  logic seq_reg, seq_next;
  logic [3:0] presc_reg, presc_next;
  logic [16:0] step_reg, step_next;
  logic strobe_reg, strobe_next;

  // continuous strobe
  logic [26:0] period_eff;
  logic [31:0] half_cycles;
  logic cont_wave;
  logic cont_reg;

  // pixel readout
  logic rd_reg, rd_next;
  logic [3:0] rd_presc_reg, rd_presc_next;
  logic [IDX_W-1:0] idx_reg, idx_next;
  logic [IDX_W-1:0] pix_idx_reg, pix_idx_next;
  logic pix_strobe_reg, pix_strobe_next;
  logic pix_last_reg, pix_last_next;
  logic [15:0] frame_reg, frame_next;

  // byte lane mask
  genvar b;
  generate
    for (b = 0; b < 4; b++)
    begin : g_lane
      assign be_mask[8*b +: 8] = {8{AVS_BYTEENABLE_IN[b]}};
    end
  endgenerate

  // bus decode, write takes effect at the edge waitrequest is low
  assign wr_fire = AVS_WRITE_IN & ~waitreq_reg;
  assign wr_bits = AVS_WRITEDATA_IN & be_mask;
  assign soft_trig = wr_fire && (AVS_ADDRESS_IN == `REG_CONTROL) &&
    wr_bits[`CTRL_SOFT_BIT];
  assign width_valid = fall_reg > rise_reg;
  assign status = '{width_valid: width_valid, readout_active: rd_reg,
    delay_pending: state_reg == acq_strobe_pkg::ACQ_DELAY,
    transfer_gate: gate_reg, cont_strobe: cont_reg,
    single_strobe: strobe_reg};

  // register writes, reads and waitrequest
  always_comb
  begin
    ctrl_next = ctrl_reg;
    trig_delay_next = trig_delay_reg;
    rise_next = rise_reg;
    fall_next = fall_reg;
    period_next = period_reg;
    readdata_next = readdata_reg;
    waitreq_next = ~((AVS_READ_IN | AVS_WRITE_IN) & waitreq_reg);
    if (wr_fire)
    begin
      case (AVS_ADDRESS_IN)
        `REG_CONTROL:
          ctrl_next = (ctrl_reg & ~be_mask[2:0]) | wr_bits[2:0];
        `REG_TRIGGER_DELAY:
          trig_delay_next = (trig_delay_reg & ~be_mask[15:0]) |
            wr_bits[15:0];
        `REG_RISE_DELAY:
          rise_next = (rise_reg & ~be_mask[15:0]) | wr_bits[15:0];
        `REG_FALL_DELAY:
          fall_next = (fall_reg & ~be_mask[15:0]) | wr_bits[15:0];
        `REG_CONT_PERIOD:
          period_next = (period_reg & ~be_mask[26:0]) | wr_bits[26:0];
        default:
          ctrl_next = ctrl_reg; // unmapped writes ignored
      endcase
    end
    if (AVS_READ_IN && waitreq_reg)
    begin
      case (AVS_ADDRESS_IN)
        `REG_CONTROL: readdata_next = {29'h0, ctrl_reg};
        `REG_TRIGGER_DELAY: readdata_next = {16'h0, trig_delay_reg};
        `REG_RISE_DELAY: readdata_next = {16'h0, rise_reg};
        `REG_FALL_DELAY: readdata_next = {16'h0, fall_reg};
        `REG_CONT_PERIOD: readdata_next = {5'h0, period_reg};
        `REG_STATUS: readdata_next = {26'h0, status};
        `REG_FRAME_COUNT: readdata_next = {16'h0, frame_reg};
        `REG_PULSE_WIDTH: readdata_next = width_valid ?
          {16'h0, fall_reg - rise_reg} : 32'h0;
        default: readdata_next = 32'h0;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      ctrl_reg <= `RST_CONTROL;
      trig_delay_reg <= `RST_TRIGGER_DELAY;
      rise_reg <= `RST_RISE_DELAY;
      fall_reg <= `RST_FALL_DELAY;
      period_reg <= `RST_CONT_PERIOD;
      readdata_reg <= 32'h0;
      waitreq_reg <= 1'b1;
    end
    else
    begin
      ctrl_reg <= ctrl_next;
      trig_delay_reg <= trig_delay_next;
      rise_reg <= rise_next;
      fall_reg <= fall_next;
      period_reg <= period_next;
      readdata_reg <= readdata_next;
      waitreq_reg <= waitreq_next;
    end
  end

  // two-flop synchroniser plus edge history on the trigger pin
  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      trig_meta_reg <= 1'b0;
      trig_sync_reg <= 1'b0;
      trig_prev_reg <= 1'b0;
    end
    else
    begin
      trig_meta_reg <= EXT_TRIGGER_IN;
      trig_sync_reg <= trig_meta_reg;
      trig_prev_reg <= trig_sync_reg;
    end
  end

  assign trig_edge = trig_sync_reg & ~trig_prev_reg;
  // inherent latency less sync overhead, plus trigger delay steps
  assign delay_target = 20'(LAT_CYC - SYNC_CYC) +
    trig_delay_reg * 20'(STEP_CYC);
  assign readout_start = (state_reg == acq_strobe_pkg::ACQ_TRANSFER) &&
    (cnt_reg == 20'(XFER_CYC - 1));

  // trigger delay, start of integration and transfer gate
  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    soi_next = 1'b0;
    case (state_reg)
      acq_strobe_pkg::ACQ_IDLE:
        if (soft_trig)
        begin
          state_next = acq_strobe_pkg::ACQ_TRANSFER;
          cnt_next = 20'h0;
          soi_next = 1'b1;
        end
        else if (trig_edge && ctrl_reg.ext_trig_enable)
        begin
          state_next = acq_strobe_pkg::ACQ_DELAY;
          cnt_next = 20'h0;
        end
      acq_strobe_pkg::ACQ_DELAY:
        if (cnt_reg >= delay_target - 20'h1)
        begin
          state_next = acq_strobe_pkg::ACQ_TRANSFER;
          cnt_next = 20'h0;
          soi_next = 1'b1;
        end
        else
        begin
          cnt_next = cnt_reg + 20'h1;
        end
      acq_strobe_pkg::ACQ_TRANSFER:
        if (readout_start)
        begin
          state_next = acq_strobe_pkg::ACQ_IDLE;
          cnt_next = 20'h0;
        end
        else
        begin
          cnt_next = cnt_reg + 20'h1;
        end
      default:
        state_next = acq_strobe_pkg::ACQ_IDLE;
    endcase
    gate_next = state_next == acq_strobe_pkg::ACQ_TRANSFER;
  end

  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      state_reg <= acq_strobe_pkg::ACQ_IDLE;
      cnt_reg <= 20'h0;
      soi_reg <= 1'b0;
      gate_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      soi_reg <= soi_next;
      gate_reg <= gate_next;
    end
  end

  // single strobe step counter from start of integration
  always_comb
  begin
    seq_next = seq_reg;
    presc_next = presc_reg;
    step_next = step_reg;
    if (soi_next)
    begin
      seq_next = 1'b1;
      presc_next = 4'h0;
      step_next = 17'h0;
    end
    else if (seq_reg)
    begin
      if (presc_reg == 4'(STEP_CYC - 1))
      begin
        presc_next = 4'h0;
        step_next = step_reg + 17'h1;
      end
      else
      begin
        presc_next = presc_reg + 4'h1;
      end
      seq_next = step_next < {1'b0, fall_reg};
    end
    strobe_next = ctrl_reg.lamp_enable && width_valid && seq_next &&
      (step_next >= {1'b0, rise_reg}) &&
      (step_next < {1'b0, fall_reg});
  end

  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      seq_reg <= 1'b0;
      presc_reg <= 4'h0;
      step_reg <= 17'h0;
      strobe_reg <= 1'b0;
    end
    else
    begin
      seq_reg <= seq_next;
      presc_reg <= presc_next;
      step_reg <= step_next;
      strobe_reg <= strobe_next;
    end
  end

  // period clamped to the legal range, half period in cycles
  assign period_eff = (period_reg < 27'(PERIOD_MIN_STEPS)) ?
    27'(PERIOD_MIN_STEPS) :
    (period_reg > 27'(CONT_PERIOD_MAX_STEPS)) ?
    27'(CONT_PERIOD_MAX_STEPS) : period_reg;
  assign half_cycles = {5'h0, period_eff} * 32'(HALF_STEP_CYC);

  // free-running, never restarted by start of integration
  cont_strobe_gen u_cont
  (
    .clk_in(CORE_CLK_IN),
    .rst_n_in(RST_N_IN),
    .run_in(ctrl_reg.cont_enable & ctrl_reg.lamp_enable),
    .half_cycles_in(half_cycles),
    .wave_out(cont_wave)
  );

  // output flop for the continuous strobe
  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      cont_reg <= 1'b0;
    end
    else
    begin
      cont_reg <= cont_wave & ctrl_reg.lamp_enable;
    end
  end

  // pixel readout, one pixel per step after the transfer
  always_comb
  begin
    rd_next = rd_reg;
    rd_presc_next = rd_presc_reg;
    idx_next = idx_reg;
    pix_idx_next = pix_idx_reg;
    pix_strobe_next = 1'b0;
    pix_last_next = 1'b0;
    frame_next = frame_reg;
    if (readout_start)
    begin
      rd_next = 1'b1;
      rd_presc_next = 4'h0;
      idx_next = '0;
    end
    else if (rd_reg)
    begin
      if (rd_presc_reg == 4'(STEP_CYC - 1))
      begin
        rd_presc_next = 4'h0;
        pix_strobe_next = 1'b1;
        pix_idx_next = idx_reg;
        if (idx_reg == IDX_W'(PIXEL_COUNT - 1))
        begin
          pix_last_next = 1'b1;
          rd_next = 1'b0;
          frame_next = frame_reg + 16'h1;
        end
        else
        begin
          idx_next = idx_reg + 1'b1;
        end
      end
      else
      begin
        rd_presc_next = rd_presc_reg + 4'h1;
      end
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      rd_reg <= 1'b0;
      rd_presc_reg <= 4'h0;
      idx_reg <= '0;
      pix_idx_reg <= '0;
      pix_strobe_reg <= 1'b0;
      pix_last_reg <= 1'b0;
      frame_reg <= 16'h0;
    end
    else
    begin
      rd_reg <= rd_next;
      rd_presc_reg <= rd_presc_next;
      idx_reg <= idx_next;
      pix_idx_reg <= pix_idx_next;
      pix_strobe_reg <= pix_strobe_next;
      pix_last_reg <= pix_last_next;
      frame_reg <= frame_next;
    end
  end

  assign AVS_READDATA_OUT = readdata_reg;
  assign AVS_WAITREQUEST_OUT = waitreq_reg;
  assign DETECTOR_TRANSFER_GATE_OUT = gate_reg;
  assign INTEGRATION_START_OUT = soi_reg;
  assign SINGLE_STROBE_OUT = strobe_reg;
  assign CONT_STROBE_OUT = cont_reg;
  assign PIXEL_STROBE_OUT = pix_strobe_reg;
  assign PIXEL_INDEX_OUT = pix_idx_reg;
  assign PIXEL_LAST_OUT = pix_last_reg;

endmodule

// *** sim/acq_strobe_checker.sv ***
/*
  Port-level timing checks of the strobe timer.
  Assumes it is bound into acquisition_strobe_timing.
*/
`timescale 1ns/100ps
`include "acq_strobe_cfg.svh"
module acq_strobe_checker
#(
  parameter int unsigned CONT_PERIOD_MAX_STEPS = 40,
  parameter int unsigned PIXEL_COUNT = 8
)
(
  input wire logic CORE_CLK_IN,
  input wire logic RST_N_IN,
  input wire logic [7:0] AVS_ADDRESS_IN,
  input wire logic AVS_READ_IN,
  input wire logic AVS_WRITE_IN,
  input wire logic [31:0] AVS_WRITEDATA_IN,
  input wire logic [3:0] AVS_BYTEENABLE_IN,
  input wire logic AVS_WAITREQUEST_OUT,
  input wire logic DETECTOR_TRANSFER_GATE_OUT,
  input wire logic INTEGRATION_START_OUT,
  input wire logic SINGLE_STROBE_OUT,
  input wire logic CONT_STROBE_OUT,
  input wire logic PIXEL_STROBE_OUT,
  input wire logic [$clog2(PIXEL_COUNT)-1:0] PIXEL_INDEX_OUT,
  input wire logic PIXEL_LAST_OUT
);
  localparam int IDX_W = $clog2(PIXEL_COUNT);
  logic lamp_reg, lamp_next;
  logic [7:0] gate_cnt_reg, gate_cnt_next;

  default clocking @(posedge CORE_CLK_IN);
  endclocking
  default disable iff (!RST_N_IN);

  // lamp bit as written by the host, gate length so far
  always_comb
  begin
    lamp_next = lamp_reg;
    if (AVS_WRITE_IN && !AVS_WAITREQUEST_OUT && AVS_BYTEENABLE_IN[0] &&
        AVS_ADDRESS_IN == `REG_CONTROL)
      lamp_next = AVS_WRITEDATA_IN[`CTRL_LAMP_BIT];
    gate_cnt_next = DETECTOR_TRANSFER_GATE_OUT ? gate_cnt_reg + 8'h01 : 8'h00;
  end

  // helper registers
  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      lamp_reg <= 1'b0;
      gate_cnt_reg <= 8'h00;
    end
    else
    begin
      lamp_reg <= lamp_next;
      gate_cnt_reg <= gate_cnt_next;
    end
  end

  wait_pulse_a: assert property (!AVS_WAITREQUEST_OUT |=> AVS_WAITREQUEST_OUT)
    else $error("waitrequest low for more than one cycle");
  bus_answer_a: assert property (($rose(AVS_READ_IN) || $rose(AVS_WRITE_IN))
    |=> !AVS_WAITREQUEST_OUT)
    else $error("no answer one cycle after request");
  start_gate_a: assert property (INTEGRATION_START_OUT |->
    $rose(DETECTOR_TRANSFER_GATE_OUT) ##1 !INTEGRATION_START_OUT)
    else $error("start pulse not on gate rise");
  gate_width_a: assert property ($fell(DETECTOR_TRANSFER_GATE_OUT) |->
    gate_cnt_reg == 8'haa)
    else $error("transfer gate width wrong");
  lamp_off_a: assert property (!lamp_reg |-> ##2
    (!SINGLE_STROBE_OUT && !CONT_STROBE_OUT))
    else $error("strobe active with lamp off");
  pixel_last_a: assert property (PIXEL_LAST_OUT |-> PIXEL_STROBE_OUT &&
    PIXEL_INDEX_OUT == IDX_W'(PIXEL_COUNT - 1))
    else $error("last pixel flag misplaced");
  pixel_step_a: assert property (PIXEL_STROBE_OUT && !PIXEL_LAST_OUT
    |=> !PIXEL_STROBE_OUT [*8] ##1 !PIXEL_STROBE_OUT ##1 (PIXEL_STROBE_OUT &&
    PIXEL_INDEX_OUT == $past(PIXEL_INDEX_OUT, 10) + 1'b1))
    else $error("pixel spacing or index wrong");
  first_pixel_a: assert property ($fell(DETECTOR_TRANSFER_GATE_OUT) |->
    ##[9:11] (PIXEL_STROBE_OUT && PIXEL_INDEX_OUT == '0))
    else $error("readout did not follow gate");
endmodule

bind acquisition_strobe_timing acq_strobe_checker
#(
  .CONT_PERIOD_MAX_STEPS(CONT_PERIOD_MAX_STEPS),
  .PIXEL_COUNT(PIXEL_COUNT)
)
i_checker
(
  .CORE_CLK_IN(CORE_CLK_IN),
  .RST_N_IN(RST_N_IN),
  .AVS_ADDRESS_IN(AVS_ADDRESS_IN),
  .AVS_READ_IN(AVS_READ_IN),
  .AVS_WRITE_IN(AVS_WRITE_IN),
  .AVS_WRITEDATA_IN(AVS_WRITEDATA_IN),
  .AVS_BYTEENABLE_IN(AVS_BYTEENABLE_IN),
  .AVS_WAITREQUEST_OUT(AVS_WAITREQUEST_OUT),
  .DETECTOR_TRANSFER_GATE_OUT(DETECTOR_TRANSFER_GATE_OUT),
  .INTEGRATION_START_OUT(INTEGRATION_START_OUT),
  .SINGLE_STROBE_OUT(SINGLE_STROBE_OUT),
  .CONT_STROBE_OUT(CONT_STROBE_OUT),
  .PIXEL_STROBE_OUT(PIXEL_STROBE_OUT),
  .PIXEL_INDEX_OUT(PIXEL_INDEX_OUT),
  .PIXEL_LAST_OUT(PIXEL_LAST_OUT)
);

// *** sim/strobe_observer.sv ***
/*
  Lamp and trigger side: drives the trigger pin and times strobe edges.
  Assumes the timer's clock; times are counted on sampled levels.
*/
`timescale 1ns/100ps
module strobe_observer
(
  input wire logic clk_in,
  input wire logic gate_in,
  input wire logic single_in,
  input wire logic cont_in,
  output logic trig_out
);
  int cyc = 0;
  int trig_t, gate_t, rise_t, fall_t, tog_t, half_len;
  int gates = 0;
  int rises = 0;
  int toggles = 0;
  logic trig_q = 1'b0;
  logic gate_q = 1'b0;
  logic single_q = 1'b0;
  logic cont_q = 1'b0;

  initial trig_out = 1'b0;

  // edge times and counts
  always @(posedge clk_in)
  begin
    cyc <= cyc + 1;
    trig_q <= trig_out;
    gate_q <= gate_in;
    single_q <= single_in;
    cont_q <= cont_in;
    if (trig_out && !trig_q) trig_t <= cyc;
    if (gate_in && !gate_q) gate_t <= cyc;
    if (single_in && !single_q) rise_t <= cyc;
    if (!single_in && single_q) fall_t <= cyc;
    if (cont_in != cont_q) half_len <= cyc - tog_t;
    if (cont_in != cont_q) tog_t <= cyc;
    gates <= gates + int'(gate_in && !gate_q);
    rises <= rises + int'(single_in && !single_q);
    toggles <= toggles + int'(cont_in != cont_q);
  end

  // trigger pulse, raised and dropped just after an edge
  task automatic pulse(input int len);
    trig_out <= 1'b1;
    repeat (len) @(posedge clk_in);
    trig_out <= 1'b0;
  endtask
endmodule

// *** sim/test_acquisition_strobe_timing.sv ***
/*
  Bench of the strobe timer: registers, soft and pin starts, strobes.
  Assumes small period and pixel counts to keep the run short.
*/
`timescale 1ns/100ps
`include "acq_strobe_cfg.svh"
module test_acquisition_strobe_timing;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] adr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [3:0] be = 4'hf;
  logic [31:0] rdat;
  logic wreq, gate, start, single, cont, pstb, plast, trig;
  logic [2:0] pidx;
  int fails = 0;
  int check_count = 0;

  acquisition_strobe_timing #(.CONT_PERIOD_MAX_STEPS(40), .PIXEL_COUNT(8))
  i_dut
  (
    .CORE_CLK_IN(clk),
    .RST_N_IN(rst_n),
    .AVS_ADDRESS_IN(adr),
    .AVS_READ_IN(rd),
    .AVS_WRITE_IN(wr),
    .AVS_WRITEDATA_IN(wdat),
    .AVS_BYTEENABLE_IN(be),
    .AVS_READDATA_OUT(rdat),
    .AVS_WAITREQUEST_OUT(wreq),
    .EXT_TRIGGER_IN(trig),
    .DETECTOR_TRANSFER_GATE_OUT(gate),
    .INTEGRATION_START_OUT(start),
    .SINGLE_STROBE_OUT(single),
    .CONT_STROBE_OUT(cont),
    .PIXEL_STROBE_OUT(pstb),
    .PIXEL_INDEX_OUT(pidx),
    .PIXEL_LAST_OUT(plast)
  );

  strobe_observer i_obs
  (
    .clk_in(clk),
    .gate_in(gate),
    .single_in(single),
    .cont_in(cont),
    .trig_out(trig)
  );

  always #25 clk = ~clk;

  // verdict and end of run
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // compare and count
  task automatic check(input string what, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one access, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] d, input logic [3:0] m, output logic [31:0] q);
    int n;
    logic ok;
    n = 0;
    adr <= a;
    wdat <= d;
    be <= m;
    wr <= w;
    rd <= !w;
    do
    begin
      @(posedge clk);
      ok = (wreq === 1'b0);
      q = rdat;
      n++;
    end
    while (!ok && n < 50);
    // no answer within the limit ends the run as a failure
    if (!ok)
    begin
      fails++;
      wrap_up;
    end
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, 4'hf, q);
  endtask

  task automatic rchk(input string s, input logic [7:0] a,
    input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, 4'hf, q);
    check(s, q, e);
  endtask

  // reset values, lanes, read-only and unmapped places
  task automatic test_regs;
    logic [31:0] q;
    rchk("control", `REG_CONTROL, 32'h0);
    rchk("period", `REG_CONT_PERIOD, 32'h7d0);
    rchk("unmapped", 8'h20, 32'h0);
    wreg(`REG_STATUS, 32'hffffffff);
    rchk("status", `REG_STATUS, 32'h0);
    wreg(`REG_RISE_DELAY, 32'h1ffff);
    rchk("rise max", `REG_RISE_DELAY, 32'hffff);
    bus(1'b1, `REG_TRIGGER_DELAY, 32'hffff, 4'h1, q);
    rchk("lane", `REG_TRIGGER_DELAY, 32'hff);
    wreg(`REG_TRIGGER_DELAY, 32'h0);
    wreg(`REG_RISE_DELAY, 32'h3);
    wreg(`REG_FALL_DELAY, 32'h5);
    rchk("width", `REG_PULSE_WIDTH, 32'h2);
    rchk("width flag", `REG_STATUS, 32'h20);
    $display("regs done");
  endtask

  // software start with lamp on
  task automatic test_soft;
    int g;
    g = i_obs.gates;
    wreg(`REG_RISE_DELAY, 32'h2);
    wreg(`REG_CONTROL, 32'h1);
    wreg(`REG_CONTROL, 32'h101);
    repeat (400) @(posedge clk);
    check("starts", i_obs.gates - g, 1);
    check("rise", i_obs.rise_t - i_obs.gate_t, 20);
    check("pulse", i_obs.fall_t - i_obs.rise_t, 30);
    rchk("frames", `REG_FRAME_COUNT, 32'h1);
    $display("soft done");
  endtask

  // lamp off, then fall equal to rise: no pulse
  task automatic test_dark;
    int r;
    for (int i = 0; i < 2; i++)
    begin
      r = i_obs.rises;
      wreg(`REG_FALL_DELAY, i ? 32'h2 : 32'h5);
      wreg(`REG_CONTROL, i ? 32'h101 : 32'h100);
      repeat (400) @(posedge clk);
      check("dark", i_obs.rises - r, 0);
    end
    $display("dark done");
  endtask

  // pin start with delay, second pin edge while delaying
  task automatic test_ext;
    int t;
    int g;
    wreg(`REG_TRIGGER_DELAY, 32'h2);
    wreg(`REG_RISE_DELAY, 32'h1);
    wreg(`REG_FALL_DELAY, 32'h3);
    wreg(`REG_CONTROL, 32'h5);
    g = i_obs.gates;
    i_obs.pulse(4);
    t = i_obs.trig_t;
    repeat (50) @(posedge clk);
    i_obs.pulse(4);
    repeat (600) @(posedge clk);
    check("one start", i_obs.gates - g, 1);
    // inherent latency plus two trigger delay steps plus one rise step
    check("latency", i_obs.rise_t - t,
      (`START_LATENCY_NS + `STEP_NS * 3) / 50);
    check("ext pulse", i_obs.fall_t - i_obs.rise_t, 20);
    $display("ext done");
  endtask

  // square wave periods, clamps and lamp gating
  task automatic test_cont;
    int per [3] = '{6, 2, 100};
    int half [3] = '{30, 20, 200};
    int n;
    for (int i = 0; i < 3; i++)
    begin
      wreg(`REG_CONT_PERIOD, per[i]);
      wreg(`REG_CONTROL, 32'h3);
      repeat (6 * half[i]) @(posedge clk);
      check("half period", i_obs.half_len, half[i]);
    end
    wreg(`REG_CONTROL, 32'h2);
    repeat (10) @(posedge clk);
    n = i_obs.toggles;
    repeat (300) @(posedge clk);
    check("lamp off toggles", i_obs.toggles - n, 0);
    check("lamp off level", cont, 1'b0);
    $display("cont done");
  endtask

  // main sequence
  initial
  begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    test_regs;
    test_soft;
    test_dark;
    test_ext;
    test_cont;
    wrap_up;
  end

  // watchdog
  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    wrap_up;
  end
endmodule
